// >>> rtl/pvp_entry_pc.sv
module pvp_entry_pc
	import pvp_pkg::*;
(
	input wire logic I_MCLK,
	input wire logic I_RSTN,
	input wire logic I_HV_MODE_SELECT_PIN,
	input wire logic I_SUPPLY_GOOD,
	input wire logic I_INTERNAL_CLEAR_OPTION,
	input wire logic I_CODE_PROTECT_BIT,
	input wire logic I_SERIAL_PROG_CLOCK,
	input wire logic I_SERIAL_PROG_DATA,
	output logic O_SERIAL_PROG_DATA,
	output logic O_SERIAL_PROG_DATA_OE_N,
	input wire logic [DATA_W-1:0] I_MEM_RDATA,
	output logic [ADDR_W-1:0] O_ADDRESS_COUNTER,
	output logic O_PROG_MODE,
	output logic O_LOGIC_RESET,
	output logic O_GPIO_FLOAT,
	output logic O_USER_CODE_BLOCKED,
	output logic O_ENTRY_ORDER_ERROR,
	output logic O_ADDR_USABLE,
	output logic O_MEM_VALID,
	input wire logic I_MEM_READY,
	output pvp_op_t O_MEM_OP,
	output logic [ADDR_W-1:0] O_MEM_ADDR,
	output logic [DATA_W-1:0] O_MEM_WDATA,
	output logic O_MEM_KEEP_CAL,
	output logic O_MEM_ERASE_IDS
);
	typedef enum logic [2:0] {
		PVP_OFF,
		PVP_HV_FIRST,
		PVP_CMD,
		PVP_GAP,
		PVP_DATA
	} pvp_state_t;

	localparam int BUF_W = ADDR_W + DATA_W + 3;
	// An unassigned code marks a finished load that still has to be queued.
	localparam logic [5:0] CMD_MARK = 6'h3f;

	logic [2:0] sclk_sync_reg, sclk_sync_next;
	logic [1:0] sdat_sync_reg, sdat_sync_next;
	logic [1:0] hv_sync_reg, hv_sync_next;
	logic [1:0] sup_sync_reg, sup_sync_next;
	logic sclk_fall, sclk_rise, sdat, hv, sup;

	pvp_state_t state_reg, state_next;
	logic [ADDR_W-1:0] addr_reg, addr_next;
	logic [5:0] cmd_reg, cmd_next;
	logic [4:0] bit_reg, bit_next;
	logic [15:0] shift_reg, shift_next;
	logic [7:0] gap_reg, gap_next;
	logic [DATA_W-1:0] rdata_reg, rdata_next;
	logic dout_reg, dout_next;
	logic oe_n_reg, oe_n_next;
	logic err_reg, err_next;
	logic blocked_reg, blocked_next;
	logic reading;

	logic q_valid;
	logic [BUF_W-1:0] q_data;
	pvp_op_t q_op;
	pvp_buf_if bif ();

	// The serial clock is slow next to I_MCLK, so its edges are found by sampling.
	always_comb begin
		sclk_sync_next = {sclk_sync_reg[1:0], I_SERIAL_PROG_CLOCK};
		sdat_sync_next = {sdat_sync_reg[0], I_SERIAL_PROG_DATA};
		hv_sync_next = {hv_sync_reg[0], I_HV_MODE_SELECT_PIN};
		sup_sync_next = {sup_sync_reg[0], I_SUPPLY_GOOD};
	end

	always_ff @(posedge I_MCLK) begin
		if (!I_RSTN) begin
			sclk_sync_reg <= '0;
			sdat_sync_reg <= '0;
			hv_sync_reg <= '0;
			sup_sync_reg <= '0;
		end else begin
			sclk_sync_reg <= sclk_sync_next;
			sdat_sync_reg <= sdat_sync_next;
			hv_sync_reg <= hv_sync_next;
			sup_sync_reg <= sup_sync_next;
		end
	end

	// The third stage on the serial clock only serves as the old value for edge finding.
	assign sclk_fall = sclk_sync_reg[2] && !sclk_sync_reg[1];
	assign sclk_rise = !sclk_sync_reg[2] && sclk_sync_reg[1];
	assign sdat = sdat_sync_reg[1];
	assign hv = hv_sync_reg[1];
	assign sup = sup_sync_reg[1];
	assign reading = (cmd_reg == CMD_READ_DATA);

	always_comb begin
		q_op = PVP_OP_NONE;
		unique case (cmd_reg)
			CMD_LOAD_CFG: q_op = PVP_OP_LOADCFG;
			CMD_LOAD_DATA: q_op = PVP_OP_LOAD;
			CMD_INC_ADDR: q_op = PVP_OP_INC;
			CMD_BEGIN_PROG: q_op = PVP_OP_PROG;
			CMD_BULK_ERASE, CMD_ROW_ERASE: q_op = PVP_OP_ERASE;
			default: q_op = PVP_OP_NONE;
		endcase
	end

	// Stalled memory work holds the serial engine rather than dropping a word.
	always_comb begin
		state_next = state_reg;
		addr_next = addr_reg;
		cmd_next = cmd_reg;
		bit_next = bit_reg;
		shift_next = shift_reg;
		gap_next = gap_reg;
		rdata_next = rdata_reg;
		dout_next = dout_reg;
		oe_n_next = oe_n_reg;
		err_next = err_reg;
		blocked_next = blocked_reg;
		q_valid = 1'b0;
		q_data = '0;
		if (!hv) begin
			state_next = PVP_OFF;
			addr_next = ADDR_RESET;
			oe_n_next = 1'b1;
			if (!sup) begin
				blocked_next = 1'b0;
			end
		end else begin
			unique case (state_reg)
				PVP_OFF: begin
					// Entry waits for clock and data low, so a busy pin never starts a frame.
					if (sclk_sync_reg[1] || sdat) begin
						state_next = PVP_OFF;
					end else begin
						state_next = sup ? PVP_CMD : PVP_HV_FIRST;
						addr_next = ADDR_RESET;
						bit_next = '0;
						shift_next = '0;
						err_next = sup && !I_INTERNAL_CLEAR_OPTION;
						blocked_next = !sup;
					end
				end
				PVP_HV_FIRST: begin
					if (sup) begin
						state_next = PVP_CMD;
					end
				end
				PVP_CMD: begin
					if (sclk_fall) begin
						cmd_next = {sdat, cmd_reg[5:1]};
						bit_next = bit_reg + 5'd1;
						if (bit_reg == 5'(CMD_BITS - 1)) begin
							bit_next = '0;
							state_next = PVP_GAP;
							gap_next = '0;
						end
					end
				end
				PVP_GAP: begin
					if (gap_reg < 8'(GAP_CYC)) begin
						gap_next = gap_reg + 8'd1;
					end else if (cmd_reg == CMD_LOAD_CFG || cmd_reg == CMD_LOAD_DATA
						|| reading) begin
						state_next = PVP_DATA;
						// The word is taken once, so a later memory change cannot tear a read.
						rdata_next = (I_CODE_PROTECT_BIT || (addr_reg >= CFG_BASE
							&& addr_reg <= UID_TOP)) ? I_MEM_RDATA : '0;
					end else begin
						q_valid = (q_op != PVP_OP_NONE);
						q_data = {q_op, addr_reg, {DATA_W{1'b0}}};
						// A queued request or a finished load waits here while the buffer is full.
						if (bif.in_ready || (q_op == PVP_OP_NONE && cmd_reg != CMD_MARK)) begin
							state_next = PVP_CMD;
							// The top bit is carried over, never computed, so configuration space is kept.
							if (cmd_reg == CMD_INC_ADDR) begin
								if (addr_reg[13]) begin
									addr_next = {1'b1, addr_reg[12:0] + 13'd1};
								end else begin
									addr_next = {1'b0, addr_reg[12:0] + 13'd1};
								end
							end
						end
					end
				end
				PVP_DATA: begin
					// The pin is driven from the second rising edge through the fifteenth; the sixteenth releases it.
					if (sclk_rise && reading) begin
						oe_n_next = (bit_reg >= 5'd1 && bit_reg < 5'(DATA_CLOCKS - 1)) ? 1'b0 : 1'b1;
						dout_next = rdata_reg[0];
						if (bit_reg >= 5'd1) begin
							rdata_next = {1'b0, rdata_reg[DATA_W-1:1]};
						end
					end
					if (sclk_fall) begin
						shift_next = {sdat, shift_reg[15:1]};
						bit_next = bit_reg + 5'd1;
						if (bit_reg == 5'(DATA_CLOCKS - 1)) begin
							oe_n_next = 1'b1;
							if (!reading) begin
								state_next = PVP_GAP;
								// Both loads queue exactly one word; the gap has already run.
								cmd_next = CMD_MARK;
							end else begin
								state_next = PVP_CMD;
							end
							bit_next = '0;
							if (cmd_reg == CMD_LOAD_CFG) begin
								addr_next = CFG_BASE;
							end
						end
					end
				end
				default: state_next = PVP_OFF;
			endcase
		end
	end

	always_ff @(posedge I_MCLK) begin
		if (!I_RSTN) begin
			state_reg <= PVP_OFF;
			addr_reg <= ADDR_RESET;
			cmd_reg <= '0;
			bit_reg <= '0;
			shift_reg <= '0;
			gap_reg <= '0;
			rdata_reg <= '0;
			dout_reg <= 1'b0;
			oe_n_reg <= 1'b1;
			err_reg <= 1'b0;
			blocked_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			addr_reg <= addr_next;
			cmd_reg <= cmd_next;
			bit_reg <= bit_next;
			shift_reg <= shift_next;
			gap_reg <= gap_next;
			rdata_reg <= rdata_next;
			dout_reg <= dout_next;
			oe_n_reg <= oe_n_next;
			err_reg <= err_next;
			blocked_reg <= blocked_next;
		end
	end

	// A completed load re-enters the gap with a marker command so it is queued once.
	always_comb begin
		bif.in_valid = q_valid;
		bif.in_data = q_data;
		if (state_reg == PVP_GAP && (cmd_reg == CMD_MARK)) begin
			bif.in_valid = 1'b1;
			bif.in_data = {PVP_OP_LOAD, addr_reg, shift_reg[14:1]};
		end
	end

	pvp_buf #(.WIDTH(BUF_W), .DEPTH(2)) u_buf (
		.i_clk(I_MCLK),
		.i_rstn(I_RSTN),
		.bus(bif)
	);

	assign bif.out_ready = I_MEM_READY;
	assign O_MEM_VALID = bif.out_valid;
	assign O_MEM_OP = pvp_op_t'(bif.out_data[BUF_W-1 -: 3]);
	assign O_MEM_ADDR = bif.out_data[DATA_W +: ADDR_W];
	assign O_MEM_WDATA = bif.out_data[DATA_W-1:0];
	// Trim words are never offered for erase; a dedicated procedure needs its own path.
	assign O_MEM_KEEP_CAL = 1'b1;
	assign O_MEM_ERASE_IDS = O_MEM_ADDR[13];
	assign O_ADDR_USABLE = !addr_reg[13] || (addr_reg <= UID_TOP) || (addr_reg == CONFIG_WORD)
		|| (addr_reg >= CAL_BASE && addr_reg <= CAL_USE_TOP);
	assign O_ADDRESS_COUNTER = addr_reg;
	assign O_PROG_MODE = (state_reg != PVP_OFF);
	// User logic stays in reset while the select is high or user code must stay blocked.
	assign O_LOGIC_RESET = hv || blocked_reg;
	assign O_GPIO_FLOAT = hv;
	assign O_USER_CODE_BLOCKED = blocked_reg;
	assign O_ENTRY_ORDER_ERROR = err_reg;
	assign O_SERIAL_PROG_DATA = dout_reg;
	assign O_SERIAL_PROG_DATA_OE_N = oe_n_reg;
endmodule : pvp_entry_pc

// >>> rtl/pvp_pkg.sv
package pvp_pkg;
	localparam int ADDR_W = 14;
	localparam int DATA_W = 14;
	localparam logic [13:0] ADDR_RESET = 14'h0000;
	localparam logic [13:0] USER_TOP = 14'h1fff;
	localparam logic [13:0] CFG_BASE = 14'h2000;
	localparam logic [13:0] CFG_TOP = 14'h3fff;
	localparam logic [13:0] CFG_IMPL_TOP = 14'h208f;
	localparam logic [13:0] UID_TOP = 14'h2003;
	localparam logic [13:0] CONFIG_WORD = 14'h2007;
	localparam logic [13:0] CAL_BASE = 14'h2080;
	localparam logic [13:0] CAL_USE_TOP = 14'h2089;
	localparam logic [13:0] CAL_TOP = 14'h208a;
	localparam int CMD_BITS = 6;
	localparam int DATA_CLOCKS = 16;
	localparam logic [5:0] CMD_LOAD_CFG = 6'h00;
	localparam logic [5:0] CMD_LOAD_DATA = 6'h02;
	localparam logic [5:0] CMD_READ_DATA = 6'h04;
	localparam logic [5:0] CMD_INC_ADDR = 6'h06;
	localparam logic [5:0] CMD_BEGIN_PROG = 6'h18;
	localparam logic [5:0] CMD_END_PROG = 6'h0a;
	localparam logic [5:0] CMD_BULK_ERASE = 6'h09;
	localparam logic [5:0] CMD_ROW_ERASE = 6'h11;
	localparam int CLK_MHZ = 50;
	localparam int GAP_NS = 1000;
	localparam int GAP_CYC = (GAP_NS * CLK_MHZ + 999) / 1000;
	typedef enum logic [2:0] {
		PVP_OP_NONE,
		PVP_OP_LOAD,
		PVP_OP_READ,
		PVP_OP_INC,
		PVP_OP_LOADCFG,
		PVP_OP_PROG,
		PVP_OP_ERASE
	} pvp_op_t;
endpackage : pvp_pkg

// >>> rtl/pvp_buf_if.sv
interface pvp_buf_if;
	import pvp_pkg::*;
	logic in_valid;
	logic in_ready;
	logic [ADDR_W+DATA_W+2:0] in_data;
	logic out_valid;
	logic out_ready;
	logic [ADDR_W+DATA_W+2:0] out_data;
	modport fill (output in_valid, output in_data, input in_ready);
	modport store (input in_valid, input in_data, output in_ready,
		output out_valid, output out_data, input out_ready);
	modport drain (input out_valid, input out_data, output out_ready);
endinterface : pvp_buf_if

// >>> rtl/pvp_buf.sv
module pvp_buf #(
	parameter int WIDTH = 31,
	parameter int DEPTH = 2
) (
	input wire logic i_clk,
	input wire logic i_rstn,
	pvp_buf_if.store bus
);
	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [WIDTH-1:0] mem_next [DEPTH];
	logic [$clog2(DEPTH):0] cnt_reg, cnt_next;
	logic push, pop;

	assign bus.in_ready = (cnt_reg < DEPTH[$clog2(DEPTH):0]);
	assign bus.out_valid = (cnt_reg != '0);
	assign bus.out_data = mem_reg[0];
	assign push = bus.in_valid && bus.in_ready;
	assign pop = bus.out_valid && bus.out_ready;

	// Entry zero is always the head, so entries shift down on a pop.
	always_comb begin
		cnt_next = cnt_reg + {{$clog2(DEPTH){1'b0}}, push} - {{$clog2(DEPTH){1'b0}}, pop};
		for (int i = 0; i < DEPTH; i++) begin
			mem_next[i] = mem_reg[i];
			if (pop && i < DEPTH - 1) begin
				mem_next[i] = mem_reg[i+1];
			end
			if (push && (i == int'(cnt_reg) - int'(pop))) begin
				mem_next[i] = bus.in_data;
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			cnt_reg <= '0;
			for (int i = 0; i < DEPTH; i++) begin
				mem_reg[i] <= '0;
			end
		end else begin
			cnt_reg <= cnt_next;
			mem_reg <= mem_next;
		end
	end
endmodule : pvp_buf

// >>> testbench/pvp_entry_pc_monitor.sv
module pvp_entry_pc_monitor
	import pvp_pkg::*;
(
	input wire logic I_MCLK,
	input wire logic I_RSTN,
	input wire logic I_INTERNAL_CLEAR_OPTION,
	input wire logic I_MEM_READY,
	input wire logic O_SERIAL_PROG_DATA_OE_N,
	input wire logic [ADDR_W-1:0] O_ADDRESS_COUNTER,
	input wire logic O_PROG_MODE,
	input wire logic O_LOGIC_RESET,
	input wire logic O_GPIO_FLOAT,
	input wire logic O_ENTRY_ORDER_ERROR,
	input wire logic O_ADDR_USABLE,
	input wire logic O_MEM_VALID,
	input wire pvp_op_t O_MEM_OP,
	input wire logic [ADDR_W-1:0] O_MEM_ADDR,
	input wire logic O_MEM_KEEP_CAL
);
	timeunit 1ns;
	timeprecision 1ps;
	wire logic [13:0] c = O_ADDRESS_COUNTER;
	wire logic m = O_PROG_MODE;
	default clocking @(posedge I_MCLK); endclocking
	default disable iff (!I_RSTN);
	property p_oe_idle; !m |-> O_SERIAL_PROG_DATA_OE_N; endproperty
	a_oe_idle: assert property (p_oe_idle) else $error("data pin driven outside mode");
	property p_zero_idle; !m [*2] |-> c == 14'h0000; endproperty
	a_zero_idle: assert property (p_zero_idle) else $error("counter not zero outside mode");
	property p_step;
		m && $past(m) && $changed(c) && $past(c) != 14'h1fff && $past(c) != 14'h3fff
			|-> c == $past(c) + 14'h0001 || c == 14'h2000;
	endproperty
	a_step: assert property (p_step) else $error("counter moved by other than one");
	property p_user_wrap; m && $past(m) && $changed(c) && $past(c) == 14'h1fff |-> c == 14'h0000;
	endproperty
	a_user_wrap: assert property (p_user_wrap) else $error("user wrap wrong");
	property p_cfg_wrap; m && $past(m) && $changed(c) && $past(c) == 14'h3fff |-> c == 14'h2000;
	endproperty
	a_cfg_wrap: assert property (p_cfg_wrap) else $error("config wrap wrong");
	property p_sticky; c[13] && m |=> c[13] || !m; endproperty
	a_sticky: assert property (p_sticky) else $error("left configuration memory");
	property p_hold;
		O_MEM_VALID && !I_MEM_READY |=> O_MEM_VALID && $stable(O_MEM_ADDR) && $stable(O_MEM_OP);
	endproperty
	a_hold: assert property (p_hold) else $error("stalled request changed");
	property p_keep_cal; O_MEM_KEEP_CAL; endproperty
	a_keep_cal: assert property (p_keep_cal) else $error("erase may touch trim words");
	property p_float; O_GPIO_FLOAT |-> O_LOGIC_RESET; endproperty
	a_float: assert property (p_float) else $error("logic not held in reset");
	property p_order; $rose(O_ENTRY_ORDER_ERROR) |-> !I_INTERNAL_CLEAR_OPTION; endproperty
	a_order: assert property (p_order) else $error("order error without clear option");
	property p_usable;
		m && c[13] && $stable(c) |-> O_ADDR_USABLE
			== (c <= 14'h2003 || c == 14'h2007 || (c >= 14'h2080 && c <= 14'h2089));
	endproperty
	a_usable: assert property (p_usable) else $error("usable flag wrong");
endmodule : pvp_entry_pc_monitor

bind pvp_entry_pc pvp_entry_pc_monitor u_mon (.I_MCLK(I_MCLK), .I_RSTN(I_RSTN),
	.I_INTERNAL_CLEAR_OPTION(I_INTERNAL_CLEAR_OPTION), .I_MEM_READY(I_MEM_READY),
	.O_SERIAL_PROG_DATA_OE_N(O_SERIAL_PROG_DATA_OE_N), .O_ADDRESS_COUNTER(O_ADDRESS_COUNTER),
	.O_PROG_MODE(O_PROG_MODE), .O_LOGIC_RESET(O_LOGIC_RESET), .O_GPIO_FLOAT(O_GPIO_FLOAT),
	.O_ENTRY_ORDER_ERROR(O_ENTRY_ORDER_ERROR), .O_ADDR_USABLE(O_ADDR_USABLE),
	.O_MEM_VALID(O_MEM_VALID), .O_MEM_OP(O_MEM_OP), .O_MEM_ADDR(O_MEM_ADDR),
	.O_MEM_KEEP_CAL(O_MEM_KEEP_CAL));

// >>> testbench/pvp_prog_model.sv
module pvp_prog_model (
	output logic o_clk,
	output logic o_data,
	output logic o_drive_en,
	output logic o_select,
	output logic o_supply,
	input wire logic i_pin
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		o_clk = 1'b0;
		o_data = 1'b0;
		o_drive_en = 1'b1;
		o_select = 1'b0;
		o_supply = 1'b0;
	end
	// Clock and data are already low here, so both orders only differ in whether select or supply rises first.
	task automatic enter(input bit hv_first);
		#5;
		if (hv_first) o_select = 1'b1;
		else o_supply = 1'b1;
		#400;
		o_select = 1'b1;
		o_supply = 1'b1;
		#400;
	endtask : enter
	task automatic leave();
		#5;
		o_supply = 1'b0;
		#400;
		o_select = 1'b0;
		#400;
	endtask : leave
	// Sampling mid-low leaves margin for the device's edge detection delay.
	task automatic shift(input logic [15:0] v, input int n, input bit rd, output logic [15:0] q);
		q = 16'h0000;
		for (int i = 0; i < n; i++) begin
			o_clk = 1'b1;
			o_drive_en = !rd;
			o_data = v[i];
			#80;
			o_clk = 1'b0;
			#40;
			q[i] = i_pin;
			#40;
		end
		o_drive_en = 1'b1;
		o_data = 1'b0;
	endtask : shift
endmodule : pvp_prog_model

// >>> testbench/program_verify_entry_and_pc_tb.sv
module program_verify_entry_and_pc_tb;
	import pvp_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk = 1'b0, rstn = 1'b0, opt = 1'b1, cp = 1'b1, mem_ready = 1'b1, flip = 1'b0;
	logic [13:0] rdata = 14'h1a5a;
	logic sclk, sdrv, sdrv_en, sel, sup, pin, dout, oe_n, pmode, lreset, gfloat, blocked, oerr;
	logic usable, mvalid, keep, eids;
	logic [13:0] cnt, maddr, mwdata;
	logic [15:0] got;
	pvp_op_t mop, last_op;
	logic [13:0] last_addr, last_wdata;
	logic last_eids;
	int mismatches = 0, n_checks = 0, cycles = 0, n_mem = 0;
	always #10 mclk = ~mclk;
	// An undriven pin shows a changing pattern so stale data never passes.
	assign pin = sdrv_en ? sdrv : (!oe_n ? dout : flip);
	pvp_prog_model prog (.o_clk(sclk), .o_data(sdrv), .o_drive_en(sdrv_en), .o_select(sel),
		.o_supply(sup), .i_pin(pin));
	pvp_entry_pc dut (.I_MCLK(mclk), .I_RSTN(rstn), .I_HV_MODE_SELECT_PIN(sel),
		.I_SUPPLY_GOOD(sup), .I_INTERNAL_CLEAR_OPTION(opt), .I_CODE_PROTECT_BIT(cp),
		.I_SERIAL_PROG_CLOCK(sclk), .I_SERIAL_PROG_DATA(pin), .O_SERIAL_PROG_DATA(dout),
		.O_SERIAL_PROG_DATA_OE_N(oe_n), .I_MEM_RDATA(rdata), .O_ADDRESS_COUNTER(cnt),
		.O_PROG_MODE(pmode), .O_LOGIC_RESET(lreset), .O_GPIO_FLOAT(gfloat),
		.O_USER_CODE_BLOCKED(blocked), .O_ENTRY_ORDER_ERROR(oerr), .O_ADDR_USABLE(usable),
		.O_MEM_VALID(mvalid), .I_MEM_READY(mem_ready), .O_MEM_OP(mop), .O_MEM_ADDR(maddr),
		.O_MEM_WDATA(mwdata), .O_MEM_KEEP_CAL(keep), .O_MEM_ERASE_IDS(eids));
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : print_verdict
	always @(posedge mclk) begin
		flip <= ~flip;
		cycles <= cycles + 1;
		if (mvalid && mem_ready) begin
			n_mem <= n_mem + 1;
			last_op <= mop;
			last_addr <= maddr;
			last_wdata <= mwdata;
			last_eids <= eids;
		end
		if (cycles == 40000) begin
			mismatches++;
			print_verdict();
		end
	end
	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task automatic cmd(input logic [5:0] c, input logic [15:0] d, input bit dat, input bit rd);
		logic [15:0] x;
		@(negedge mclk);
		prog.shift({10'h000, c}, 6, 1'b0, x);
		#1200;
		if (dat) begin
			prog.shift(d, 16, rd, got);
			#1200;
		end
	endtask : cmd
	task automatic t_idle();
		cmd(CMD_INC_ADDR, 16'h0000, 1'b0, 1'b0);
		check("count", cnt, 16'h0000);
		check("mode", pmode, 16'h0000);
		check("oe_n", oe_n, 16'h0001);
	endtask : t_idle
	task automatic t_user();
		prog.enter(1'b1);
		check("mode", pmode, 16'h0001);
		check("blocked", blocked, 16'h0001);
		check("reset", lreset, 16'h0001);
		check("float", gfloat, 16'h0001);
		check("count", cnt, 16'h0000);
		for (int i = 1; i <= 3; i++) begin
			cmd(CMD_INC_ADDR, 16'h0000, 1'b0, 1'b0);
			check("count", cnt, 16'(i));
		end
		check("op", last_op, PVP_OP_INC);
		cmd(CMD_LOAD_DATA, {1'b0, 14'h1234, 1'b0}, 1'b1, 1'b0);
		check("load op", last_op, PVP_OP_LOAD);
		check("load addr", last_addr, 16'h0003);
		check("load data", last_wdata, 16'h1234);
		check("count", cnt, 16'h0003);
		cmd(CMD_BEGIN_PROG, 16'h0000, 1'b0, 1'b0);
		check("prog op", last_op, PVP_OP_PROG);
		check("count", cnt, 16'h0003);
		@(posedge mclk) cp <= 1'b0;
		cmd(CMD_READ_DATA, 16'hffff, 1'b1, 1'b1);
		check("protected read", got[14:1], 16'h0000);
	endtask : t_user
	task automatic t_stall();
		int n0;
		@(posedge mclk) mem_ready <= 1'b0;
		n0 = n_mem;
		cmd(CMD_INC_ADDR, 16'h0000, 1'b0, 1'b0);
		cmd(CMD_INC_ADDR, 16'h0000, 1'b0, 1'b0);
		check("count", cnt, 16'h0005);
		check("held", mvalid, 16'h0001);
		cmd(CMD_INC_ADDR, 16'h0000, 1'b0, 1'b0);
		check("stalled", cnt, 16'h0005);
		@(posedge mclk) mem_ready <= 1'b1;
		repeat (10) @(posedge mclk);
		check("count", cnt, 16'h0006);
		check("drained", 16'(n_mem - n0), 16'h0003);
		check("empty", mvalid, 16'h0000);
	endtask : t_stall
	task automatic t_config();
		cmd(CMD_LOAD_CFG, {1'b0, 14'h0055, 1'b0}, 1'b1, 1'b0);
		check("count", cnt, 16'(CFG_BASE));
		check("cfg addr", last_addr, 16'(CFG_BASE));
		check("cfg data", last_wdata, 16'h0055);
		cmd(CMD_READ_DATA, 16'hffff, 1'b1, 1'b1);
		check("id read", got[14:1], 16'(rdata));
		for (int a = 'h2001; a <= 'h208b; a++) begin
			cmd(CMD_INC_ADDR, 16'h0000, 1'b0, 1'b0);
			check("count", cnt, 16'(a));
			check("usable", usable, 16'(a <= 'h2003 || a == 'h2007
				|| (a >= 'h2080 && a <= 'h2089)));
		end
		cmd(CMD_BULK_ERASE, 16'h0000, 1'b0, 1'b0);
		check("erase op", last_op, PVP_OP_ERASE);
		check("erase ids", last_eids, 16'h0001);
		check("keep cal", keep, 16'h0001);
		check("count", cnt, 16'h208b);
	endtask : t_config
	task automatic t_exit();
		prog.leave();
		check("mode", pmode, 16'h0000);
		check("count", cnt, 16'h0000);
		check("blocked", blocked, 16'h0000);
		@(posedge mclk) opt <= 1'b0;
		prog.enter(1'b1);
		check("count", cnt, 16'h0000);
		check("order", oerr, 16'h0000);
		check("blocked", blocked, 16'h0001);
		prog.leave();
	endtask : t_exit
	task automatic t_supply();
		@(posedge mclk) opt <= 1'b1;
		prog.enter(1'b0);
		check("mode", pmode, 16'h0001);
		check("order", oerr, 16'h0000);
		check("blocked", blocked, 16'h0000);
		prog.leave();
		@(posedge mclk) opt <= 1'b0;
		prog.enter(1'b0);
		check("order", oerr, 16'h0001);
		prog.leave();
	endtask : t_supply
	initial begin
		repeat (2) @(posedge mclk);
		rstn <= 1'b1;
		repeat (3) @(posedge mclk);
		t_idle();
		t_user();
		t_stall();
		t_config();
		t_exit();
		t_supply();
		print_verdict();
	end
endmodule : program_verify_entry_and_pc_tb
